// ==== design/wdtpm_top.sv ====
/*
 * Watchdog timer with count source protective mode behind an AXI4-Lite
 * register slave. Assumes all inputs are synchronous to aclk and that the
 * on-chip oscillator arrives as a one-cycle tick pulse in the aclk domain.
 */
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module wdtpm_top
	import wdtpm_pkg::*;
#(
	parameter int CW = CNT_WIDTH
)
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        sub_clock_sel,
	input  wire logic        osc_tick,
	input  wire logic        wait_mode,
	input  wire logic        hold_state,
	output logic             stop_mode,
	output logic             osc_enable,
	output logic             wdt_reset,
	output logic             irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [CW-1:0]        count;
	logic [PRE_WIDTH-1:0] presc;
	logic                 running;
	logic                 div_sel;
	logic                 unlock;
	logic                 rst_sel;
	logic                 protect;
	logic                 irq_stat;
	logic                 irq_mask;

	function automatic logic [PRE_WIDTH-1:0] presc_limit(input logic sub, input logic sel);
		if (sub)
			return DIV_SUB;
		return sel ? DIV_SLOW : DIV_FAST;
	endfunction

	// ----------------------------------------------------------------
	// bus write decode
	// ----------------------------------------------------------------
	wdtpm_wr_s wr;
	wire wr_fire = awready && awvalid && wready && wvalid;
	assign wr.addr = awaddr;
	assign wr.data = wdata;
	assign wr.strb = wstrb;
	wire lane0         = wr.strb[0];
	wire wr_restart    = wr_fire && (wr.addr == OFS_RESTART);
	wire wr_control    = wr_fire && lane0 && (wr.addr == OFS_CONTROL);
	wire wr_protect    = wr_fire && lane0 && (wr.addr == OFS_PROTECT);
	wire wr_mode1      = wr_fire && lane0 && (wr.addr == OFS_MODE1) && unlock;
	wire wr_mode2      = wr_fire && lane0 && (wr.addr == OFS_MODE2) && unlock;
	wire wr_clkctl     = wr_fire && lane0 && (wr.addr == OFS_CLKCTL1);
	wire wr_irq_stat   = wr_fire && lane0 && (wr.addr == OFS_IRQ_STAT);
	wire wr_irq_mask   = wr_fire && lane0 && (wr.addr == OFS_IRQ_MASK);
	wire wr_mapped     = (wr.addr == OFS_RESTART) || (wr.addr == OFS_CONTROL)
		|| (wr.addr == OFS_PROTECT) || (wr.addr == OFS_MODE1)
		|| (wr.addr == OFS_MODE2) || (wr.addr == OFS_CLKCTL1)
		|| (wr.addr == OFS_COUNT) || (wr.addr == OFS_IRQ_STAT)
		|| (wr.addr == OFS_IRQ_MASK);

	// ----------------------------------------------------------------
	// counting path
	// ----------------------------------------------------------------
	wdtpm_lowpower_s lp;
	assign lp.stop_mode  = stop_mode;
	assign lp.wait_mode  = wait_mode;
	assign lp.hold_state = hold_state;
	// protect mode keeps the watchdog alive through wait and hold
	wire halted     = protect ? 1'b0 : (lp.stop_mode || lp.wait_mode || lp.hold_state);
	wire active     = running && !halted;
	wire [PRE_WIDTH-1:0] limit = presc_limit(sub_clock_sel, div_sel);
	// a larger count left by a slower ratio must not run on to the 7-bit wrap
	wire presc_wrap = (presc >= limit);
	wire cnt_tick   = active && (protect ? osc_tick : presc_wrap);
	wire underflow  = cnt_tick && (count == '0);
	wire uf_reset   = underflow && rst_sel;
	wire uf_irq     = underflow && !rst_sel;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			presc <= PRE_RESET;
		else if (wr_restart || protect)
			presc <= PRE_RESET;
		else if (active)
			presc <= presc_wrap ? PRE_RESET : presc + 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count   <= CNT_RELOAD;
			running <= 1'b0;
		end
		else if (wr_restart)
		begin
			count   <= CNT_RELOAD;
			running <= 1'b1;
		end
		else if (uf_reset)
		begin
			count   <= CNT_RELOAD;
			running <= 1'b0;
		end
		else if (cnt_tick)
			count   <= (count == '0) ? CNT_RELOAD : count - 1'b1;
	end

	// ----------------------------------------------------------------
	// mode and control bits
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_sel <= 1'b0;
			unlock  <= 1'b0;
			rst_sel <= 1'b0;
			protect <= 1'b0;
		end
		else
		begin
			if (wr_control)
				div_sel <= wr.data[BIT_DIV_SEL];
			if (wr_protect)
				unlock  <= wr.data[BIT_UNLOCK];
			if (wr_mode1 && wr.data[BIT_RST_SEL])
				rst_sel <= 1'b1;
			if (wr_mode2)
				protect <= wr.data[BIT_PROTECT_SEL];
		end
	end

	// stop mode ends on any unmasked interrupt, as a wake-up would
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			stop_mode <= 1'b0;
		else if (protect || irq)
			stop_mode <= 1'b0;
		else if (wr_clkctl)
			stop_mode <= wr.data[BIT_CLK_STOP];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			osc_enable <= 1'b0;
			wdt_reset  <= 1'b0;
		end
		else
		begin
			osc_enable <= protect;
			wdt_reset  <= uf_reset;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	wire clr_stat = wr_irq_stat && wr.data[BIT_UNDERFLOW];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_stat <= 1'b0;
			irq_mask <= 1'b0;
			irq      <= 1'b0;
		end
		else
		begin
			// a new underflow beats a clear in the same cycle
			irq_stat <= uf_irq || (irq_stat && !clr_stat);
			if (wr_irq_mask)
				irq_mask <= wr.data[BIT_UNDERFLOW];
			irq      <= (uf_irq || (irq_stat && !clr_stat)) && (wr_irq_mask ?
				wr.data[BIT_UNDERFLOW] : irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// write channel handshake
	// ----------------------------------------------------------------
	wire next_wready = !awready && awvalid && wvalid && !bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end
		else
		begin
			awready <= next_wready;
			wready  <= next_wready;
			if (wr_fire)
			begin
				bvalid <= 1'b1;
				bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	wire rd_fire = arready && arvalid;
	logic [31:0] rd_word;
	logic        rd_ok;

	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (araddr)
			OFS_RESTART:  rd_word = 32'h0000_0000;
			OFS_CONTROL:  rd_word[BIT_DIV_SEL] = div_sel;
			OFS_PROTECT:  rd_word[BIT_UNLOCK] = unlock;
			OFS_MODE1:    rd_word[BIT_RST_SEL] = rst_sel;
			OFS_MODE2:    rd_word[BIT_PROTECT_SEL] = protect;
			OFS_CLKCTL1:  rd_word[BIT_CLK_STOP] = stop_mode;
			OFS_COUNT:
			begin
				rd_word[CW-1:0]      = count;
				rd_word[BIT_RUNNING] = running;
			end
			OFS_IRQ_STAT: rd_word[BIT_UNDERFLOW] = irq_stat;
			OFS_IRQ_MASK: rd_word[BIT_UNDERFLOW] = irq_mask;
			default:      rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end
		else
		begin
			arready <= !arready && arvalid && !rvalid;
			if (rd_fire)
			begin
				rvalid <= 1'b1;
				rdata  <= rd_word;
				rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

endmodule

// ==== design/wdtpm_pkg.sv ====
/*
 * Constants and types for the protected watchdog timer: register offsets,
 * field positions, reset values, prescaler ratios and bus response codes.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package wdtpm_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_RESTART   = 8'h00;
	localparam logic [7:0] OFS_CONTROL   = 8'h04;
	localparam logic [7:0] OFS_PROTECT   = 8'h08;
	localparam logic [7:0] OFS_MODE1     = 8'h0C;
	localparam logic [7:0] OFS_MODE2     = 8'h10;
	localparam logic [7:0] OFS_CLKCTL1   = 8'h14;
	localparam logic [7:0] OFS_COUNT     = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_DIV_SEL     = 7;
	localparam int BIT_UNLOCK      = 1;
	localparam int BIT_RST_SEL     = 2;
	localparam int BIT_PROTECT_SEL = 2;
	localparam int BIT_CLK_STOP    = 0;
	localparam int BIT_RUNNING     = 15;
	localparam int BIT_UNDERFLOW   = 0;

	// ----------------------------------------------------------------
	// counter and prescaler figures
	// ----------------------------------------------------------------
	localparam int CNT_WIDTH = 15;
	localparam logic [CNT_WIDTH-1:0] CNT_RELOAD = 15'h7FFF;
	localparam int PRE_WIDTH = 7;
	localparam logic [PRE_WIDTH-1:0] DIV_SLOW = 7'h7F;
	localparam logic [PRE_WIDTH-1:0] DIV_FAST = 7'h0F;
	localparam logic [PRE_WIDTH-1:0] DIV_SUB  = 7'h01;
	localparam logic [PRE_WIDTH-1:0] PRE_RESET = 7'h00;

	// ----------------------------------------------------------------
	// bus responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} wdtpm_wr_s;

	typedef struct packed {
		logic stop_mode;
		logic wait_mode;
		logic hold_state;
	} wdtpm_lowpower_s;

endpackage

// ==== sim/wdtpm_chk.sv ====
/* wdtpm_chk: port-level properties of wdtpm_top.
   assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
module wdtpm_chk
#(
	parameter int CW = 15
)
(
	input logic aclk,
	input logic aresetn,
	input logic awready,
	input logic wready,
	input logic bvalid,
	input logic arready,
	input logic rvalid,
	input logic stop_mode,
	input logic osc_enable,
	input logic wdt_reset,
	input logic irq
);
	// ----------------
	// properties
	// ----------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_aw_w_pair: assert property (awready |-> wready)
		else $error("address and data not taken together");
	chk_b_answer: assert property (awready |=> bvalid)
		else $error("write answer late");
	chk_r_answer: assert property (arready |=> rvalid)
		else $error("read answer late");
	chk_b_busy: assert property (bvalid |-> !awready)
		else $error("write taken while answer pending");
	chk_r_busy: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	chk_ar_pulse: assert property (arready |=> !arready)
		else $error("read ready longer than a cycle");
	chk_rst_pulse: assert property (wdt_reset |=> !wdt_reset)
		else $error("watchdog reset longer than a cycle");
	// only a bus write can take the level down
	chk_irq_cause: assert property ($fell(irq) |-> $past(awready) || $past(awready, 2))
		else $error("interrupt dropped without a write");
	chk_stop_block: assert property (osc_enable && $past(osc_enable) |-> !stop_mode)
		else $error("stop mode while protected");
endmodule

bind wdtpm_top wdtpm_chk #(.CW(CW)) wdtpm_chk_i (.aclk(aclk), .aresetn(aresetn),
	.awready(awready), .wready(wready), .bvalid(bvalid), .arready(arready),
	.rvalid(rvalid), .stop_mode(stop_mode), .osc_enable(osc_enable),
	.wdt_reset(wdt_reset), .irq(irq));

// ==== sim/test_watchdog_timer_with_protect_mode.sv ====
/* bench: drives wdtpm_top over AXI4-Lite and checks count rates and periods.
   assumes two-cycle bus answers and osc_tick sampled on aclk. */
`timescale 1ns/1ps
module test_watchdog_timer_with_protect_mode;
	import wdtpm_pkg::*;
	// ----------------
	// signals
	// ----------------
	logic        aclk = 1'h0, aresetn = 1'h0, sub_clock_sel = 1'h0, osc_tick = 1'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
	logic        rready = 1'h0, wait_mode = 1'h0, hold_state = 1'h0, osc_run = 1'h0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, v, rdata;
	logic [3:0]  wstrb = 4'hF;
	logic [1:0]  bresp, rresp, rsp;
	logic        awready, wready, bvalid, arready, rvalid, stop_mode, osc_enable;
	logic        wdt_reset, irq;
	int          mismatches = 0, checked = 0, cyc = 0, a, n;
	// reference model of the software-visible control bits
	int          m_div = 0, m_unlock = 0, m_rst = 0, m_prot = 0, m_stop = 0, m_mask = 0;
	logic [7:0]  ra[$] = '{OFS_CONTROL, OFS_PROTECT, OFS_MODE1, OFS_MODE2, OFS_CLKCTL1,
		OFS_IRQ_MASK};

	wdtpm_top wdtpm_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .sub_clock_sel, .osc_tick, .wait_mode, .hold_state,
		.stop_mode, .osc_enable, .wdt_reset, .irq);

	always #2.5 aclk = ~aclk;

	// random oscillator ticks must be ignored until protection is on
	always @(posedge aclk)
	begin
		osc_tick <= osc_run | 1'($urandom);
		cyc++;
		if (cyc == 90000)
		begin
			mismatches++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want)
		begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic inrange(input int x, input int lo, input int hi);
		check({31'h0, x >= lo && x <= hi}, 32'h1);
	endtask

	// model: apply a write as the rules describe it
	task automatic model_wr(input logic [7:0] ad, input logic [31:0] d);
		case (ad)
			OFS_CONTROL:  m_div = d[BIT_DIV_SEL];
			OFS_PROTECT:  m_unlock = d[BIT_UNLOCK];
			OFS_MODE1:    m_rst = m_rst | (m_unlock & d[BIT_RST_SEL]);
			OFS_MODE2:
			begin
				m_prot = m_unlock ? d[BIT_PROTECT_SEL] : m_prot;
				m_stop = m_prot ? 0 : m_stop;
			end
			OFS_CLKCTL1:  m_stop = m_prot ? 0 : d[BIT_CLK_STOP];
			OFS_IRQ_MASK: m_mask = d[BIT_UNDERFLOW];
			default:      ;
		endcase
	endtask

	function automatic logic [31:0] model_rd(input logic [7:0] ad);
		case (ad)
			OFS_CONTROL:  return m_div << BIT_DIV_SEL;
			OFS_PROTECT:  return m_unlock << BIT_UNLOCK;
			OFS_MODE1:    return m_rst << BIT_RST_SEL;
			OFS_MODE2:    return m_prot << BIT_PROTECT_SEL;
			OFS_CLKCTL1:  return m_stop << BIT_CLK_STOP;
			OFS_IRQ_MASK: return m_mask << BIT_UNDERFLOW;
			default:      return 32'h0;
		endcase
	endfunction

	task automatic regs();
		foreach (ra[i])
		begin
			rd(ra[i]);
			check(v, model_rd(ra[i]));
		end
	endtask

	// ----------------
	// bus tasks
	// ----------------
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do @(posedge aclk); while (awready !== 1'h1);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		do @(posedge aclk); while (bvalid !== 1'h1);
		rsp = bresp;
		bready <= 1'h0;
		model_wr(ad, d);
	endtask

	task automatic rd(input logic [7:0] ad);
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge aclk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		do @(posedge aclk); while (rvalid !== 1'h1);
		v = rdata;
		rsp = rresp;
		rready <= 1'h0;
	endtask

	task automatic still(input int k);
		rd(OFS_COUNT);
		a = v;
		repeat (k) @(posedge aclk);
		rd(OFS_COUNT);
		check(v, a);
	endtask

	// prescaler phase is unknown, so allow eight cycles and one tick above k / d, none below
	task automatic rate(input int k, input int d);
		rd(OFS_COUNT);
		a = v[14:0];
		repeat (k) @(posedge aclk);
		rd(OFS_COUNT);
		inrange(a - v[14:0], k / d, (k + 8) / d + 1);
	endtask

	task automatic until_high(input logic rst);
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while ((rst ? wdt_reset : irq) !== 1'h1);
	endtask

	initial
	begin
		n = $urandom(32'h8629FBDE);
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		still(40);
		check(v, 32'h7FFF);
		wr(OFS_MODE1, 32'h4);
		rd(OFS_MODE1);
		check(v, 32'h0);
		wr(8'h40, 32'h1);
		check(rsp, RESP_SLVERR);
		rd(8'h40);
		check(v, 32'h0);
		check(rsp, RESP_SLVERR);
		wr(OFS_CONTROL, 32'h80);
		regs();
		sub_clock_sel <= 1'h1;
		wr(OFS_RESTART, $urandom);
		rate(40 + $urandom % 40, 2);
		sub_clock_sel <= 1'h0;
		rate(1280, 128);
		wr(OFS_CONTROL, 32'h0);
		rate(320, 16);
		for (n = 0; n < 3; n++)
		begin
			wait_mode <= n == 0;
			hold_state <= n == 1;
			if (n == 2)
				wr(OFS_CLKCTL1, 32'h1);
			still(100);
		end
		check({31'h0, stop_mode}, 32'h1);
		wr(OFS_PROTECT, 32'h2);
		wr(OFS_MODE2, 32'h4);
		@(posedge aclk);
		check({30'h0, osc_enable, stop_mode}, 32'h2);
		regs();
		wr(OFS_CLKCTL1, 32'h1);
		repeat (2) @(posedge aclk);
		check({31'h0, stop_mode}, 32'h0);
		osc_run <= 1'h1;
		wait_mode <= 1'h1;
		hold_state <= 1'h1;
		rate(100, 1);
		wr(OFS_IRQ_MASK, 32'h1);
		wr(OFS_RESTART, 32'h0);
		until_high(1'h0);
		inrange(n, 32760, 32775);
		rd(OFS_COUNT);
		inrange(v, 32'hFFF0, 32'hFFFF);
		rd(OFS_IRQ_STAT);
		check(v, 32'h1);
		wr(OFS_IRQ_STAT, 32'h1);
		repeat (2) @(posedge aclk);
		check({31'h0, irq}, 32'h0);
		wr(OFS_MODE1, 32'h4);
		wr(OFS_MODE1, 32'h0);
		rd(OFS_MODE1);
		check(v, 32'h4);
		wr(OFS_PROTECT, 32'h0);
		regs();
		wr(OFS_RESTART, 32'h0);
		until_high(1'h1);
		inrange(n, 32760, 32775);
		report_and_stop();
	end
endmodule
